// ---- src/sdbr_blink.sv ----
// Blink divider for the run indicator.
// Assumes the same clock and reset as the controller.
`timescale 1ns/10ps
`default_nettype none

module sdbr_blink
#(
   parameter int HALF_CYCLES = sdbr_pkg::BLINK_HALF_CYCLES
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Blink output
   output logic blink
);

   typedef struct packed
   {
      logic [31:0] count;
      logic level;
   } sdbr_blink_state_type;

   sdbr_blink_state_type state_reg;
   sdbr_blink_state_type state_next;

   always_comb
   begin
      state_next = state_reg;
      if (state_reg.count >= 32'(HALF_CYCLES - 1))
      begin
         state_next.count = 32'h0;
         state_next.level = ~state_reg.level;
      end
      else
      begin
         state_next.count = state_reg.count + 32'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign blink = state_reg.level;

endmodule // sdbr_blink

`default_nettype wire

// ---- src/sdbr_ctrl.sv ----
// Screen data backup/restore controller with APB register access.
// Assumes switch pins are asynchronous and a flash engine reports phase
// completion and failures through the transfer register.
`timescale 1ns/10ps
`default_nettype none

module sdbr_ctrl
#(
   parameter int BLINK_HALF_CYCLES = sdbr_pkg::BLINK_HALF_CYCLES
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Memory unit pins
   input wire logic unit_present,
   input wire logic [7:0] switch_pins,
   // Flash engine command
   output logic xfer_start,
   output sdbr_pkg::sdbr_xfer_type xfer_cmd,
   // Operator outputs
   output sdbr_pkg::sdbr_phase_type phase,
   output sdbr_pkg::sdbr_error_type error_code,
   output logic run_indicator,
   output logic buzzer,
   output logic normal_operation_allowed
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      ST_SAMPLE,
      ST_MANUAL,
      ST_RUN,
      ST_HALT
   } sdbr_ctrl_mode_type;

   typedef struct packed
   {
      logic [7:0] sync1;
      logic [7:0] sync2;
      logic present1;
      logic present2;
      sdbr_pkg::sdbr_switch_type sw;
      sdbr_ctrl_mode_type mode;
      sdbr_pkg::sdbr_phase_type phase;
      sdbr_pkg::sdbr_error_type err;
      logic manual_to_unit;
      logic manual_bank;
      logic is_auto;
      logic start;
      sdbr_pkg::sdbr_xfer_type cmd;
      logic [31:0] rdata;
   } sdbr_ctrl_state_type;

   sdbr_ctrl_state_type state_reg;
   sdbr_ctrl_state_type state_next;
   logic blink;

   // Exactly-one-hot check over the three mode switches
   function automatic logic mode_valid(input sdbr_pkg::sdbr_switch_type s);
      logic [1:0] n;
      n = 2'(s.auto_restore_select) + 2'(s.auto_backup_select)
         + 2'(s.manual_transfer_select);
      return n == 2'h1;
   endfunction

   function automatic logic write_allowed(input sdbr_pkg::sdbr_switch_type s,
      input logic to_unit);
      return to_unit ? s.unit_write_enable : s.terminal_write_enable;
   endfunction

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   logic wr_en;
   logic rd_en;
   logic mapped;
   assign mapped = (paddr == sdbr_pkg::CTRL_OFFSET)
      || (paddr == sdbr_pkg::STATUS_OFFSET)
      || (paddr == sdbr_pkg::SWITCH_OFFSET)
      || (paddr == sdbr_pkg::XFER_OFFSET);
   assign wr_en = psel && penable && pwrite && mapped;
   assign rd_en = psel && !penable && !pwrite;

   logic press_dir;
   logic press_bank;
   logic press_exec;
   logic press_ack;
   logic phase_done;
   logic init_fail;
   logic write_fail;
   logic verify_fail;
   always_comb
   begin
      press_dir = 1'b0;
      press_bank = 1'b0;
      press_exec = 1'b0;
      press_ack = 1'b0;
      phase_done = 1'b0;
      init_fail = 1'b0;
      write_fail = 1'b0;
      verify_fail = 1'b0;
      if (wr_en && paddr == sdbr_pkg::CTRL_OFFSET)
      begin
         press_dir = pwdata[sdbr_pkg::CTRL_DIR_BIT];
         press_bank = pwdata[sdbr_pkg::CTRL_BANK_BIT];
         press_exec = pwdata[sdbr_pkg::CTRL_EXEC_BIT];
         press_ack = pwdata[sdbr_pkg::CTRL_ACK_BIT];
      end
      if (wr_en && paddr == sdbr_pkg::XFER_OFFSET)
      begin
         phase_done = pwdata[sdbr_pkg::XFER_PHASE_DONE_BIT];
         init_fail = pwdata[sdbr_pkg::XFER_INIT_FAIL_BIT];
         write_fail = pwdata[sdbr_pkg::XFER_WRITE_FAIL_BIT];
         verify_fail = pwdata[sdbr_pkg::XFER_VERIFY_FAIL_BIT];
      end
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      state_next = state_reg;
      state_next.start = 1'b0;
      // Pins pass two flops before use
      state_next.sync1 = switch_pins;
      state_next.sync2 = state_reg.sync1;
      state_next.present1 = unit_present;
      state_next.present2 = state_reg.present1;

      case (state_reg.mode)
         ST_SAMPLE:
         begin
            // Waits for present2 so sync2 holds pin values taken with the unit present
            if (state_reg.present2)
            begin
               state_next.sw = state_reg.sync2;
               if (!mode_valid(state_reg.sync2))
               begin
                  state_next.err = sdbr_pkg::ERR_MODE;
                  state_next.mode = ST_HALT;
               end
               else if (state_reg.sync2[2])
               begin
                  state_next.mode = ST_MANUAL;
               end
               else
               begin
                  // Bank switch only matters for automatic transfers
                  state_next.is_auto = 1'b1;
                  state_next.cmd.to_unit = state_reg.sync2[1];
                  state_next.cmd.bank = state_reg.sync2[6];
                  if (!write_allowed(state_reg.sync2, state_reg.sync2[1]))
                  begin
                     state_next.err = sdbr_pkg::ERR_PROTECT;
                     state_next.mode = ST_HALT;
                  end
                  else
                  begin
                     state_next.mode = ST_RUN;
                     state_next.start = 1'b1;
                     state_next.phase = sdbr_pkg::PHASE_PREPARING;
                  end
               end
            end
         end
         ST_MANUAL:
         begin
            if (state_reg.err == sdbr_pkg::ERR_PROTECT)
            begin
               if (press_ack)
               begin
                  state_next.err = sdbr_pkg::ERR_NONE;
               end
            end
            else if (press_exec)
            begin
               state_next.cmd.to_unit = state_reg.manual_to_unit;
               state_next.cmd.bank = state_reg.manual_bank;
               if (!write_allowed(state_reg.sw, state_reg.manual_to_unit))
               begin
                  state_next.err = sdbr_pkg::ERR_PROTECT;
               end
               else
               begin
                  state_next.mode = ST_RUN;
                  state_next.start = 1'b1;
                  state_next.phase = sdbr_pkg::PHASE_PREPARING;
               end
            end
            else
            begin
               state_next.manual_to_unit = state_reg.manual_to_unit ^ press_dir;
               state_next.manual_bank = state_reg.manual_bank ^ press_bank;
            end
         end
         ST_RUN:
         begin
            if (init_fail || write_fail)
            begin
               state_next.err = sdbr_pkg::ERR_FLASH;
               state_next.mode = ST_HALT;
            end
            else if (verify_fail
               && state_reg.phase == sdbr_pkg::PHASE_VERIFYING)
            begin
               state_next.err = sdbr_pkg::ERR_VERIFY;
               state_next.mode = ST_HALT;
            end
            else if (phase_done)
            begin
               case (state_reg.phase)
                  sdbr_pkg::PHASE_PREPARING:
                     state_next.phase = sdbr_pkg::PHASE_TRANSMITTING;
                  sdbr_pkg::PHASE_TRANSMITTING:
                     state_next.phase = sdbr_pkg::PHASE_VERIFYING;
                  default:
                  begin
                     state_next.phase = sdbr_pkg::PHASE_FINISHED;
                     state_next.mode = ST_HALT;
                  end
               endcase
            end
         end
         default:
         begin
            // Finished or latched error: only reset leaves here
            state_next.mode = ST_HALT;
         end
      endcase

      // Write permissions follow the sampled switches and the transfer direction
      state_next.cmd.terminal_write_allow = state_next.sw.terminal_write_enable
         && !state_next.cmd.to_unit;
      state_next.cmd.unit_write_allow = state_next.sw.unit_write_enable
         && state_next.cmd.to_unit;
      state_next.cmd.terminal_read_only = state_next.cmd.to_unit;

      state_next.rdata = 32'h0;
      if (rd_en)
      begin
         case (paddr)
            sdbr_pkg::STATUS_OFFSET:
               state_next.rdata = {22'h0, state_reg.manual_bank,
                  state_reg.manual_to_unit, 2'(state_reg.mode),
                  3'(state_reg.err), 3'(state_reg.phase)};
            sdbr_pkg::SWITCH_OFFSET:
               state_next.rdata = {24'h0, state_reg.sw};
            default:
               state_next.rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------
   // Run indicator blink
   // ----------------------------------------------------------------
   sdbr_blink #(.HALF_CYCLES(BLINK_HALF_CYCLES)) u_blink
   (
      .pclk(pclk),
      .presetn(presetn),
      .blink(blink)
   );

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   logic err_active;
   assign err_active = state_reg.err != sdbr_pkg::ERR_NONE;

   always_comb
   begin
      if (err_active)
      begin
         run_indicator = blink;
      end
      else if (state_reg.phase == sdbr_pkg::PHASE_FINISHED)
      begin
         run_indicator = 1'b1;
      end
      else if (state_reg.mode == ST_RUN)
      begin
         run_indicator = blink;
      end
      else
      begin
         run_indicator = 1'b0;
      end
   end

   assign buzzer = err_active;
   assign error_code = state_reg.err;
   assign phase = state_reg.phase;
   assign xfer_start = state_reg.start;
   assign xfer_cmd = state_reg.cmd;
   // Lowered as soon as the unit is seen, and held until reset
   assign normal_operation_allowed = !state_reg.present2
      && state_reg.mode == ST_SAMPLE;

   // Reads are registered in setup, so every access ends in one wait-free phase
   assign prdata = state_reg.rdata;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

endmodule // sdbr_ctrl

`default_nettype wire

// ---- src/sdbr_pkg.sv ----
// Package for the screen data backup/restore controller.
// Assumes a single 200 MHz clock domain; no import, use sdbr_pkg::name.
package sdbr_pkg;

   // ----------------------------------------------------------------
   // Register map (APB, byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;
   localparam logic [7:0] SWITCH_OFFSET = 8'h08;
   localparam logic [7:0] XFER_OFFSET = 8'h0c;

   // CTRL write bits: pulses from touch panel
   localparam int CTRL_DIR_BIT = 0;
   localparam int CTRL_BANK_BIT = 1;
   localparam int CTRL_EXEC_BIT = 2;
   localparam int CTRL_ACK_BIT = 3;

   // XFER write bits: flash engine results
   localparam int XFER_PHASE_DONE_BIT = 0;
   localparam int XFER_INIT_FAIL_BIT = 1;
   localparam int XFER_WRITE_FAIL_BIT = 2;
   localparam int XFER_VERIFY_FAIL_BIT = 3;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 200;
   localparam int BLINK_HALF_MS = 250;
   localparam int BLINK_HALF_CYCLES = BLINK_HALF_MS * CLK_MHZ * 1000;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0]
   {
      PHASE_IDLE,
      PHASE_PREPARING,
      PHASE_TRANSMITTING,
      PHASE_VERIFYING,
      PHASE_FINISHED
   } sdbr_phase_type;

   typedef enum logic [2:0]
   {
      ERR_NONE,
      ERR_MODE,
      ERR_PROTECT,
      ERR_FLASH,
      ERR_VERIFY
   } sdbr_error_type;

   // Switches as sampled at startup
   typedef struct packed
   {
      logic protect_group_reserved;
      logic auto_bank_select;
      logic unit_write_enable;
      logic terminal_write_enable;
      logic mode_group_reserved;
      logic manual_transfer_select;
      logic auto_backup_select;
      logic auto_restore_select;
   } sdbr_switch_type;

   // Command to the flash engine
   typedef struct packed
   {
      logic to_unit;
      logic bank;
      logic terminal_write_allow;
      logic unit_write_allow;
      logic terminal_read_only;
   } sdbr_xfer_type;

   localparam logic [7:0] SWITCH_RESET = 8'h00;

endpackage : sdbr_pkg

// ---- verif/sdbr_ctrl_props.sv ----
// Port checker for the backup/restore controller.
// Assumes one clock domain; bound to sdbr_ctrl below.
`timescale 1ns/10ps
`default_nettype none

module sdbr_ctrl_chk
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Watched ports
   input wire logic unit_present,
   input wire logic xfer_start,
   input wire logic [2:0] phase,
   input wire logic [2:0] error_code,
   input wire logic run_indicator,
   input wire logic buzzer,
   input wire logic normal_operation_allowed
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   AST_BUZZ: assert property (
      buzzer == (error_code != sdbr_pkg::ERR_NONE))
      else $error("buzzer differs from error state");
   AST_START_PREP: assert property (
      xfer_start |-> phase == sdbr_pkg::PHASE_PREPARING)
      else $error("start without preparing phase");
   AST_START_IDLE: assert property (
      xfer_start |-> $past(phase) == sdbr_pkg::PHASE_IDLE)
      else $error("start outside idle");
   AST_PHASE_STEP: assert property (
      (phase != $past(phase) && phase > sdbr_pkg::PHASE_PREPARING)
      |-> phase == $past(phase) + 3'h1)
      else $error("phase skipped");
   AST_FIN_LIT: assert property (
      phase == sdbr_pkg::PHASE_FINISHED |-> run_indicator)
      else $error("indicator not steady when finished");
   AST_FIN_HOLD: assert property (
      phase == sdbr_pkg::PHASE_FINISHED
      |=> phase == sdbr_pkg::PHASE_FINISHED && !xfer_start)
      else $error("finished state left");
   AST_LATCH: assert property (
      error_code inside {sdbr_pkg::ERR_MODE, sdbr_pkg::ERR_FLASH,
      sdbr_pkg::ERR_VERIFY} |=> $stable(error_code))
      else $error("latched error changed");
   AST_MODE_QUIET: assert property (
      error_code == sdbr_pkg::ERR_MODE
      |-> !xfer_start && phase == sdbr_pkg::PHASE_IDLE)
      else $error("transfer despite mode error");
   AST_PROT_QUIET: assert property (
      error_code == sdbr_pkg::ERR_PROTECT |-> !xfer_start)
      else $error("transfer despite protect error");
   AST_UNIT_HOLD: assert property (
      unit_present [*4] |-> !normal_operation_allowed)
      else $error("normal operation with unit attached");

   cover property (phase == sdbr_pkg::PHASE_FINISHED);
   cover property (error_code == sdbr_pkg::ERR_PROTECT);
   cover property (error_code == sdbr_pkg::ERR_FLASH);
   cover property (error_code == sdbr_pkg::ERR_VERIFY);
endmodule // sdbr_ctrl_chk

bind sdbr_ctrl sdbr_ctrl_chk chk_u
(
   .pclk(pclk),
   .presetn(presetn),
   .unit_present(unit_present),
   .xfer_start(xfer_start),
   .phase(phase),
   .error_code(error_code),
   .run_indicator(run_indicator),
   .buzzer(buzzer),
   .normal_operation_allowed(normal_operation_allowed)
);
`default_nettype wire

// ---- verif/sdbr_unit_model.sv ----
// Memory unit model: presence pin and two switch groups.
// Assumes the bench may also change the switches after reset, once they are sampled.
`timescale 1ns/10ps
`default_nettype none

module sdbr_unit_model
(
   // Clock
   input wire logic pclk,
   // Bench control
   input wire logic attach,
   input wire logic [7:0] sw,
   // Connector pins
   output logic unit_present,
   output logic [7:0] switch_pins
);
   // Floating pins without a unit: never a steady level
   logic [7:0] junk = 8'h5a;

   always_ff @(posedge pclk)
      junk <= ~junk;

   assign unit_present = attach;
   // Reserved switches of both groups kept off
   assign switch_pins = attach ? {1'b0, sw[6:4], 1'b0, sw[2:0]} : junk;
endmodule // sdbr_unit_model
`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking bench for the backup/restore controller.
// Assumes the checker is bound and the unit model drives the pins.
`timescale 1ns/10ps
`default_nettype none

module tb_top;
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic unit_present;
   logic [7:0] switch_pins;
   logic attach;
   logic [7:0] sw;
   logic xfer_start;
   sdbr_pkg::sdbr_xfer_type xfer_cmd;
   sdbr_pkg::sdbr_phase_type phase;
   sdbr_pkg::sdbr_error_type error_code;
   logic run_indicator;
   logic buzzer;
   logic normal_operation_allowed;
   int fails;
   int num_checks;
   logic [31:0] rd;
   logic err;

   sdbr_ctrl #(.BLINK_HALF_CYCLES(4)) dut_u
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .unit_present(unit_present),
      .switch_pins(switch_pins), .xfer_start(xfer_start),
      .xfer_cmd(xfer_cmd), .phase(phase), .error_code(error_code),
      .run_indicator(run_indicator), .buzzer(buzzer),
      .normal_operation_allowed(normal_operation_allowed)
   );

   sdbr_unit_model unit_u
   (
      .pclk(pclk), .attach(attach), .sw(sw),
      .unit_present(unit_present), .switch_pins(switch_pins)
   );

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic timed_out();
      fails++;
      conclude();
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
      input string msg);
      num_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      if (n >= 20)
         timed_out();
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask

   task automatic start(input logic [7:0] s, input logic a);
      @(posedge pclk);
      sw <= s;
      attach <= a;
      presetn <= 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
   endtask

   // Waits for a transfer start or an error
   task automatic settle();
      int n;
      n = 0;
      while (xfer_start !== 1'b1 && error_code === sdbr_pkg::ERR_NONE
         && n < 40)
      begin
         @(posedge pclk);
         #1;
         n++;
      end
      if (n >= 40)
         timed_out();
   endtask

   task automatic blinks(output int c);
      logic last;
      last = run_indicator;
      c = 0;
      repeat (12)
      begin
         @(posedge pclk);
         #1;
         if (run_indicator !== last)
            c++;
         last = run_indicator;
      end
   endtask

   task automatic step(input sdbr_pkg::sdbr_phase_type p);
      apb(1'b1, sdbr_pkg::XFER_OFFSET, 32'h1);
      check(phase, p, "phase step");
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic sc_backup();
      int c;
      // Terminal locked as the source
      start(8'h62, 1'b0);
      repeat (8) @(posedge pclk);
      #1;
      check(normal_operation_allowed, 1, "no unit");
      @(posedge pclk);
      attach <= 1'b1;
      settle();
      check(xfer_start, 1, "backup start");
      check(xfer_cmd.to_unit, 1, "backup dir");
      check(xfer_cmd.bank, 1, "backup bank");
      check(xfer_cmd.unit_write_allow, 1, "unit we");
      check(xfer_cmd.terminal_write_allow, 0, "src we");
      check(xfer_cmd.terminal_read_only, 1, "src ro");
      check(phase, sdbr_pkg::PHASE_PREPARING, "prep");
      check(normal_operation_allowed, 0, "unit on");
      @(posedge pclk);
      sw <= 8'h11;
      blinks(c);
      check(c >= 2, 1, "blink in run");
      step(sdbr_pkg::PHASE_TRANSMITTING);
      step(sdbr_pkg::PHASE_VERIFYING);
      step(sdbr_pkg::PHASE_FINISHED);
      blinks(c);
      check(c, 0, "steady");
      check(run_indicator, 1, "lit");
      apb(1'b0, sdbr_pkg::SWITCH_OFFSET, 32'h0);
      check(rd[7:0], 8'h62, "sampled once");
      apb(1'b1, sdbr_pkg::CTRL_OFFSET, 32'h1 << sdbr_pkg::CTRL_EXEC_BIT);
      check(xfer_start, 0, "no restart");
      check(phase, sdbr_pkg::PHASE_FINISHED, "stay");
   endtask

   task automatic sc_restore(input int steps, input int fbit,
      input sdbr_pkg::sdbr_error_type e);
      int c;
      // Unit locked as the source
      start(8'h11, 1'b1);
      settle();
      check(xfer_cmd.to_unit, 0, "restore dir");
      check(xfer_cmd.bank, 0, "restore bank");
      check(xfer_cmd.terminal_write_allow, 1, "term we");
      check(xfer_cmd.unit_write_allow, 0, "unit kept");
      if (steps > 0)
         step(sdbr_pkg::PHASE_TRANSMITTING);
      if (steps > 1)
         step(sdbr_pkg::PHASE_VERIFYING);
      apb(1'b1, sdbr_pkg::XFER_OFFSET, 32'h1 << fbit);
      check(error_code, e, "engine fault");
      check(buzzer, 1, "buzzer");
      blinks(c);
      check(c >= 2, 1, "error blink");
      apb(1'b1, sdbr_pkg::CTRL_OFFSET, 32'h1 << sdbr_pkg::CTRL_ACK_BIT);
      check(error_code, e, "still latched");
   endtask

   task automatic sc_bad_setup();
      logic [7:0] modes [6] = '{8'h00, 8'h03, 8'h05, 8'h06, 8'h07, 8'h30};
      logic [7:0] prot [2] = '{8'h21, 8'h52};
      foreach (modes[i])
      begin
         start(modes[i], 1'b1);
         settle();
         check(error_code, sdbr_pkg::ERR_MODE, "mode");
      end
      foreach (prot[i])
      begin
         start(prot[i], 1'b1);
         settle();
         check(error_code, sdbr_pkg::ERR_PROTECT, "prot");
         apb(1'b1, sdbr_pkg::CTRL_OFFSET, 32'h1 << sdbr_pkg::CTRL_ACK_BIT);
         check(error_code, sdbr_pkg::ERR_PROTECT, "auto");
      end
   endtask

   task automatic press(input int b);
      apb(1'b1, sdbr_pkg::CTRL_OFFSET, 32'h1 << b);
   endtask

   task automatic sc_manual();
      logic d;
      logic k;
      start(8'h14, 1'b1);
      repeat (8) @(posedge pclk);
      apb(1'b0, sdbr_pkg::STATUS_OFFSET, 32'h0);
      d = rd[8];
      k = rd[9];
      check(error_code, sdbr_pkg::ERR_NONE, "waits");
      press(sdbr_pkg::CTRL_DIR_BIT);
      press(sdbr_pkg::CTRL_BANK_BIT);
      apb(1'b0, sdbr_pkg::STATUS_OFFSET, 32'h0);
      check(rd[9:8], {~k, ~d}, "toggles");
      if (rd[8] !== 1'b1)
         press(sdbr_pkg::CTRL_DIR_BIT);
      press(sdbr_pkg::CTRL_EXEC_BIT);
      check(error_code, sdbr_pkg::ERR_PROTECT, "locked");
      press(sdbr_pkg::CTRL_ACK_BIT);
      check(error_code, sdbr_pkg::ERR_NONE, "ack");
      press(sdbr_pkg::CTRL_DIR_BIT);
      apb(1'b0, sdbr_pkg::STATUS_OFFSET, 32'h0);
      check(rd[9:8], 2'b10, "panel kept");
      press(sdbr_pkg::CTRL_EXEC_BIT);
      check(xfer_start, 1, "exec");
      check(xfer_cmd.to_unit, 0, "panel dir");
      check(xfer_cmd.bank, 1, "panel bank");
      apb(1'b1, sdbr_pkg::XFER_OFFSET, 32'h1 << sdbr_pkg::XFER_WRITE_FAIL_BIT);
      check(error_code, sdbr_pkg::ERR_FLASH, "write");
      apb(1'b0, 8'h10, 32'h0);
      check(err, 1, "unmapped error");
      check(rd, 32'h0, "unmapped data");
   endtask

   // ------------------------------------------------------------
   // Clock and main sequence
   // ------------------------------------------------------------
   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      attach = 1'b0;
      sw = 8'h00;
      fails = 0;
      num_checks = 0;
      sc_backup();
      sc_restore(0, sdbr_pkg::XFER_INIT_FAIL_BIT, sdbr_pkg::ERR_FLASH);
      sc_restore(2, sdbr_pkg::XFER_VERIFY_FAIL_BIT, sdbr_pkg::ERR_VERIFY);
      sc_bad_setup();
      sc_manual();
      conclude();
   end
endmodule // tb_top
`default_nettype wire
